// file: verilog/ssd_consts.svh
// Constants of the synchronous burst memory data path
// Assumes inclusion by the package and the top module
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH
`define SSD_BURST_W 2
`define SSD_BEAT_ONE 2'h1
`define SSD_BEAT_ZERO 2'h0
`endif

// file: verilog/ssd_pkg.sv
// Types of the synchronous burst memory data path
// Assumes nothing beyond the constants header
`include "ssd_consts.svh"
`default_nettype none
package ssd_pkg;
    typedef enum logic [1:0] {
        SSD_DESEL,
        SSD_READ,
        SSD_WRITE
    } ssd_cycle_type;
endpackage : ssd_pkg
`default_nettype wire

// file: verilog/ssd_sram.sv
// Synchronous flow-through burst memory: array, burst counter and data/parity I/O path
// Assumes a controller synchronous to sys_clk_i; the pin wire is resolved outside from the
// output enables, which are low while this module drives
`include "ssd_consts.svh"
`default_nettype none
module ssd_sram #(
    parameter int ADDR_W  = 19,
    parameter int LANES   = 4
) (
    // Clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    // Control
    input  wire logic               clock_enable_n_i,
    input  wire logic               advance_or_load_i,
    input  wire logic               chip_select_a_n_i,
    input  wire logic               chip_select_b_i,
    input  wire logic               chip_select_c_n_i,
    input  wire logic               write_enable_n_i,
    input  wire logic [LANES-1:0]   byte_write_select_n_i,
    input  wire logic               output_enable_n_i,
    input  wire logic               burst_mode_i,
    input  wire logic [ADDR_W-1:0]  addr_i,
    // Data and parity pins
    input  wire logic [8*LANES-1:0] data_io_lines_i,
    output logic      [8*LANES-1:0] data_io_lines_o,
    output logic      [8*LANES-1:0] data_io_lines_oe_n_o,
    input  wire logic [LANES-1:0]   parity_io_lines_i,
    output logic      [LANES-1:0]   parity_io_lines_o,
    output logic      [LANES-1:0]   parity_io_lines_oe_n_o
);
    localparam int DW = 9 * LANES;
    localparam int BW = `SSD_BURST_W;

    logic [DW-1:0]          mem [0:(1<<ADDR_W)-1];
    ssd_pkg::ssd_cycle_type cyc;
    ssd_pkg::ssd_cycle_type next_cyc;
    logic [ADDR_W-1:0]      next_addr;
    logic [DW-1:0]          next_rd;
    logic                   next_drive;
    logic [ADDR_W-1:0]      base;
    logic [ADDR_W-1:0]      next_base;
    logic [BW-1:0]          beat;
    logic [BW-1:0]          next_beat;
    logic [LANES-1:0]       wsel;
    logic [LANES-1:0]       next_wsel;
    logic [ADDR_W-1:0]      cur_addr;
    logic [DW-1:0]          rd_word;
    logic [DW-1:0]          wr_word;
    logic                   drive_ok;
    logic                   selected;

    // Low address bits for the current beat
    function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                                input logic [BW-1:0] cnt,
                                                input logic          inter);
        if (inter) begin
            burst_low = start ^ cnt;
        end else begin
            burst_low = start + cnt;
        end
    endfunction : burst_low

    assign selected = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    assign cur_addr = {base[ADDR_W-1:BW], burst_low(base[BW-1:0], beat, burst_mode_i)};

    always_comb begin
        next_cyc      = cyc;
        next_base     = base;
        next_beat     = beat;
        next_wsel     = wsel;
        if (!clock_enable_n_i) begin
            if (advance_or_load_i) begin
                next_beat = beat + `SSD_BEAT_ONE;
            end else if (!selected) begin
                next_cyc = ssd_pkg::SSD_DESEL;
            end else begin
                next_base = addr_i;
                next_beat = `SSD_BEAT_ZERO;
                next_wsel = ~byte_write_select_n_i;
                next_cyc  = write_enable_n_i ? ssd_pkg::SSD_READ : ssd_pkg::SSD_WRITE;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cyc      <= ssd_pkg::SSD_DESEL;
            base     <= '0;
            beat     <= `SSD_BEAT_ZERO;
            wsel     <= '0;
        end else begin
            cyc      <= next_cyc;
            base     <= next_base;
            beat     <= next_beat;
            wsel     <= next_wsel;
        end
    end

    // Write data is taken at the edge closing the write cycle
    always_comb begin
        wr_word = mem[cur_addr];
        for (int l = 0; l < LANES; l++) begin
            if (wsel[l]) begin
                wr_word[8*l +: 8]     = data_io_lines_i[8*l +: 8];
                wr_word[8*LANES + l]  = parity_io_lines_i[l];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_n_i && !clock_enable_n_i && cyc == ssd_pkg::SSD_WRITE) begin
            mem[cur_addr] <= wr_word;
        end
    end

    // Read register, loaded at the edge that samples the read address
    always_comb begin
        next_addr  = {next_base[ADDR_W-1:BW],
                      burst_low(next_base[BW-1:0], next_beat, burst_mode_i)};
        next_rd    = rd_word;
        next_drive = drive_ok;
        if (!clock_enable_n_i) begin
            next_drive = (next_cyc == ssd_pkg::SSD_READ);
            if (cyc == ssd_pkg::SSD_WRITE && next_addr == cur_addr) begin
                // Write landing at this edge
                next_rd = wr_word;
            end else begin
                next_rd = mem[next_addr];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_word  <= '0;
            drive_ok <= 1'b0;
        end else begin
            rd_word  <= next_rd;
            drive_ok <= next_drive;
        end
    end

    // Pin drive: data from the read register, direction also from the asynchronous enable
    assign data_io_lines_o        = rd_word[8*LANES-1:0];
    assign parity_io_lines_o      = rd_word[DW-1 -: LANES];
    assign data_io_lines_oe_n_o   = {(8*LANES){output_enable_n_i || !drive_ok}};
    assign parity_io_lines_oe_n_o = {LANES{output_enable_n_i || !drive_ok}};

    // Steps watched by the assertions
    sequence ssd_load_s;
        !clock_enable_n_i && !advance_or_load_i && selected;
    endsequence

    sequence ssd_read_load_s;
        !clock_enable_n_i && !advance_or_load_i && selected && write_enable_n_i;
    endsequence

    sequence ssd_step_s;
        !clock_enable_n_i && advance_or_load_i;
    endsequence

    sequence ssd_write_phase_s;
        !clock_enable_n_i && (cyc == ssd_pkg::SSD_WRITE);
    endsequence

    oe_high_float_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        output_enable_n_i
        |-> (&data_io_lines_oe_n_o) && (&parity_io_lines_oe_n_o))
        else $error("pins driven while output enable is high");

    write_float_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cyc == ssd_pkg::SSD_WRITE)
        |-> (&data_io_lines_oe_n_o) && (&parity_io_lines_oe_n_o))
        else $error("pins driven during write data");

    desel_float_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cyc == ssd_pkg::SSD_DESEL)
        |-> (&data_io_lines_oe_n_o) && (&parity_io_lines_oe_n_o))
        else $error("pins driven while deselected");

    read_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ssd_read_load_s ##1 !output_enable_n_i
        |-> (data_io_lines_oe_n_o == '0) && (parity_io_lines_oe_n_o == '0))
        else $error("read data not driven");

    flow_data_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cyc == ssd_pkg::SSD_READ)
        |-> (data_io_lines_o == mem[cur_addr][8*LANES-1:0])
            && (parity_io_lines_o == mem[cur_addr][DW-1 -: LANES]))
        else $error("read data differs from the addressed word");

    suspend_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        clock_enable_n_i
        |=> $stable(data_io_lines_o) && $stable(cyc) && $stable(base) && $stable(beat))
        else $error("suspended edge changed the access");

    burst_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ssd_step_s
        |=> beat == $past(beat) + `SSD_BEAT_ONE)
        else $error("burst counter did not step");

    addr_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ssd_load_s
        |=> (base == $past(addr_i)) && (beat == `SSD_BEAT_ZERO))
        else $error("new address not loaded");

    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            lane_write_a: assert property (@(posedge sys_clk_i)
                disable iff (!rst_n_i)
                ssd_write_phase_s ##0 wsel[g]
                |=> (mem[$past(cur_addr)][8*g +: 8] == $past(data_io_lines_i[8*g +: 8]))
                    && (mem[$past(cur_addr)][8*LANES+g] == $past(parity_io_lines_i[g])))
                else $error("selected lane not written");

            lane_keep_a: assert property (@(posedge sys_clk_i)
                disable iff (!rst_n_i)
                ssd_write_phase_s ##0 !wsel[g]
                |=> (mem[$past(cur_addr)][8*g +: 8] == $past(mem[cur_addr][8*g +: 8]))
                    && (mem[$past(cur_addr)][8*LANES+g] == $past(mem[cur_addr][8*LANES+g])))
                else $error("unselected lane changed");
        end
    endgenerate
endmodule : ssd_sram
`default_nettype wire

// file: sim/ssd_ctl.sv
// Controller side of the pins: write data drive and wire level
// Assumes the memory drives while its output enable is low
`default_nettype none
module ssd_ctl (
    input  wire logic        sys_clk_i,
    input  wire logic        drv_i,
    input  wire logic [35:0] wd_i,
    input  wire logic [35:0] q_i,
    input  wire logic [35:0] oe_n_i,
    output logic      [35:0] pin_o
);
    timeunit 1ns / 1ps;
    logic [35:0] last = 36'h0;
    always_ff @(posedge sys_clk_i) last <= pin_o;
    // Floating lines show the inverse of their last level
    always_comb begin
        for (int i = 0; i < 36; i++) begin
            pin_o[i] = !oe_n_i[i] ? q_i[i] : drv_i ? wd_i[i] : !last[i];
        end
    end
endmodule : ssd_ctl
`default_nettype wire

// file: sim/sync_sram_data_io_path_tb.sv
// Bench: controller stimulus, memory model and read comparison
// Assumes write data one clock after its command, read data in the next cycle
`default_nettype none
module sync_sram_data_io_path_tb;
    timeunit 1ns / 1ps;
    logic sys_clk = 0, rst_n = 0, clk_en_n = 0, step = 0, cs_a_n = 1, cs_b = 1;
    logic cs_c_n = 0, we_n = 1, oe_n = 0, mode = 0, drv = 0, pw = 0, pr = 0, pd = 1;
    logic [3:0] bw_n = 4'hf, pb;
    logic [1:0] cnt = 2'h0;
    logic [7:0] addr = 8'h00, base = 8'h00, pa;
    logic [35:0] wd = 36'h0, q, oe_o, pin, mem [256];
    logic [31:0] seed = 32'h3d28edf7;
    int n_mismatch = 0, samples_checked = 0;
    ssd_sram #(.ADDR_W(8), .LANES(4)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .clock_enable_n_i(clk_en_n), .advance_or_load_i(step), .chip_select_a_n_i(cs_a_n),
        .chip_select_b_i(cs_b), .chip_select_c_n_i(cs_c_n), .write_enable_n_i(we_n),
        .byte_write_select_n_i(bw_n), .output_enable_n_i(oe_n), .burst_mode_i(mode),
        .addr_i(addr), .data_io_lines_i(pin[31:0]), .data_io_lines_o(q[31:0]),
        .data_io_lines_oe_n_o(oe_o[31:0]), .parity_io_lines_i(pin[35:32]),
        .parity_io_lines_o(q[35:32]), .parity_io_lines_oe_n_o(oe_o[35:32]));
    ssd_ctl ctl (.sys_clk_i(sys_clk), .drv_i(drv), .wd_i(wd), .q_i(q), .oe_n_i(oe_o),
        .pin_o(pin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    // One cycle: kind 0 read, 1 write, 2 deselect; o raises output enable
    task automatic cyc(input int k, input logic s, input logic [7:0] a, input logic [3:0] b,
                       input logic o);
        logic [31:0] t;
        @(negedge sys_clk);
        oe_n = o;
        clk_en_n = 0;
        #1;
        if (pr) chk("read", o ? oe_o : pin, o ? 36'hf_ffff_ffff : mem[pa]);
        if (pd || pw) chk("float", oe_o, 36'hf_ffff_ffff);
        t = rnd();
        wd = {t[3:0], rnd()};
        drv = pw;
        for (int i = 0; i < 4; i++) begin
            if (pw && !pb[i]) mem[pa][32+i] = wd[32+i];
            if (pw && !pb[i]) mem[pa][8*i+:8] = wd[8*i+:8];
        end
        cnt = s ? cnt + 2'h1 : 2'h0;
        base = s ? base : a;
        pa = {base[7:2], mode ? base[1:0] ^ cnt : base[1:0] + cnt};
        {we_n, step, addr, bw_n, pb} = {k != 1, s, a, b, b};
        {cs_a_n, cs_b, cs_c_n} = k != 2 ? 3'h2 : t[5] ? 3'h3 : t[4] ? 3'h0 : 3'h6;
        {pw, pr, pd} = {k == 1, k == 0, k == 2};
    endtask : cyc
    // Suspended edge: clock enable high, every other pin held
    task automatic hold();
        @(negedge sys_clk);
        clk_en_n = 1;
        #1;
        if (pr) chk("held read", pin, mem[pa]);
    endtask : hold
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #50us;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1;
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            for (int i = 0; i < 4; i++) cyc(1, 0, 8'h40 + 8'(i), 4'h0, 0);
            cyc(1, 0, 8'h41, 4'(rnd()), 0);
            cyc(0, 0, 8'h41, 4'hf, 0);
            for (int i = 0; i < 3; i++) begin
                cyc(0, 1, 8'h00, 4'hf, 0);
                if (i == 1) hold();
            end
            cyc(0, 0, 8'h42, 4'hf, 0);
            cyc(2, 0, 8'h00, 4'hf, 1);
            cyc(2, 0, 8'h00, 4'hf, 0);
            $display("burst order %0d done", m);
        end
        close_out();
    end
endmodule : sync_sram_data_io_path_tb
`default_nettype wire
